/* aicg_pkg.sv */
// aicg_pkg: constants for the clock-generation and setup-protection block.
// assumes a 32-bit AHB-Lite register bus and one system clock.
package aicg_pkg;
  // ==========================================================
  // clocking
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned HW_CNT_W   = 15;
  localparam int unsigned NUM_HW_CLK = 5;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_KEY      = 8'h00;
  localparam logic [7:0] OFS_PART     = 8'h04;
  localparam logic [7:0] OFS_DIR      = 8'h08;
  localparam logic [7:0] OFS_RATE     = 8'h0C;
  localparam logic [7:0] OFS_RX_DIV   = 8'h10;
  localparam logic [7:0] OFS_OUT_MULT = 8'h14;
  localparam logic [7:0] OFS_SERVO    = 8'h18;
  localparam logic [7:0] OFS_HW0      = 8'h1C;
  localparam logic [7:0] OFS_FILT     = 8'h30;
  localparam logic [7:0] OFS_STATUS   = 8'h34;
  // ==========================================================
  // key and reset values
  localparam logic [31:0] UNLOCK_VALUE   = 32'hAAAAAAAA;
  localparam logic [31:0] KEY_RESET      = 32'h00000000;
  localparam logic [31:0] RATE_RESET     = 32'h0000234B;
  localparam logic [1:0]  DIR_RESET      = 2'h0;
  localparam logic [1:0]  RX_DIV_RESET   = 2'h0;
  localparam logic [1:0]  OUT_MULT_RESET = 2'h0;
  localparam logic [3:0]  SERVO_RESET    = 4'h3;
  localparam logic [3:0]  HW_DIV_RESET   = 4'h5;
  localparam logic [3:0]  FILT_RESET     = 4'h4;
  // arbitrary neutral accessory code, six decimal digits
  localparam logic [31:0] PART_CODE      = 32'h0001E240;
  // ==========================================================
  // direction select bits: bit0 phase input, bit1 servo input
  localparam int unsigned DIR_PHASE_IN = 0;
  localparam int unsigned DIR_SERVO_IN = 1;
endpackage

/* aicg_top.sv */
// aicg_top: phase/servo clock generation or reception, hardware clock
// enables, and key-protected setup registers on an AHB-Lite slave.
// assumes one clk_sys; backplane clock pins are asynchronous inputs.
//
// Behaviour
// R1: protected write needs key equal AAAAAAAA
// R2: key clears to zero after protected write
// R3: host rewrites key before each protected write
// R4: readable six-digit accessory part code
// R5: select 0 drives clocks, 3 receives
// R6: host picks lowest IC as source
// R7: phase rate set in hertz, 9035
// R8: received phase locks internal phase loop
// R9: received phase divided by setting plus one
// R10: driven phase multiplied by setting plus one
// R11: servo equals phase over divider plus one
// R12: servo divider resets to three
// R13: received servo clock overrides servo divider
// R14: six hardware clocks, divide by 2^n
// R15: five hardware clocks from source clock
// R16: five dividers default to five
// R17: filter clock from sampling clock, default four
// R18: hardware clocks are local only
// R19: backplane clocks pace host and receivers
// R20: divided clocks are one-cycle enables
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module aicg_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // backplane phase clock pin
  input  wire logic        phase_pin_in,
  output logic             phase_pin_out,
  output logic             phase_pin_oe,
  // backplane servo clock pin
  input  wire logic        servo_pin_in,
  output logic             servo_pin_out,
  output logic             servo_pin_oe,
  // internal clock enables
  output logic             phase_tick,
  output logic             servo_tick,
  output logic [5:0]       hw_clk_en
);
  // ==========================================================
  // registers
  logic [31:0] write_unlock_key;
  logic [1:0]  clock_direction_select;
  logic [31:0] phase_rate_hz;
  logic [1:0]  received_phase_divider;
  logic [1:0]  output_phase_multiplier;
  logic [3:0]  servo_divider_setting;
  logic [3:0]  hw_div [0:5];
  logic        phase_locked;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [7:0]  rd_addr;
  logic        wr_prot;
  logic        key_ok;
  logic        prot_wr;
  logic        phase_rx;
  logic        servo_rx;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign phase_rx  = clock_direction_select[aicg_pkg::DIR_PHASE_IN];
  assign servo_rx  = clock_direction_select[aicg_pkg::DIR_SERVO_IN];
  assign rd_addr   = {haddr[7:2], 2'b00};

  // ==========================================================
  // bus address phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel & htrans[1] & hwrite;
      wr_addr <= {haddr[7:2], 2'b00};
    end
  end

  // every setup register except the key itself is protected
  assign wr_prot = wr_pend && (wr_addr != aicg_pkg::OFS_KEY)
                   && (wr_addr != aicg_pkg::OFS_PART)
                   && (wr_addr <= aicg_pkg::OFS_FILT);
  // R1: key must hold unlock value
  assign key_ok  = (write_unlock_key == aicg_pkg::UNLOCK_VALUE);
  assign prot_wr = wr_prot & key_ok;

  // ==========================================================
  // key register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      write_unlock_key <= aicg_pkg::KEY_RESET;
    end else if (wr_pend && wr_addr == aicg_pkg::OFS_KEY) begin
      write_unlock_key <= hwdata;
    end else if (prot_wr) begin
      // R2: self-clear after use
      write_unlock_key <= aicg_pkg::KEY_RESET;
    end
  end

  // ==========================================================
  // protected setup registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clock_direction_select  <= aicg_pkg::DIR_RESET;
      // R7: default rate in hertz
      phase_rate_hz           <= aicg_pkg::RATE_RESET;
      received_phase_divider  <= aicg_pkg::RX_DIV_RESET;
      output_phase_multiplier <= aicg_pkg::OUT_MULT_RESET;
      // R12: servo divider default
      servo_divider_setting   <= aicg_pkg::SERVO_RESET;
    end else if (prot_wr) begin
      case (wr_addr)
        aicg_pkg::OFS_DIR:      clock_direction_select  <= hwdata[1:0];
        aicg_pkg::OFS_RATE:     phase_rate_hz           <= hwdata;
        aicg_pkg::OFS_RX_DIV:   received_phase_divider  <= hwdata[1:0];
        aicg_pkg::OFS_OUT_MULT: output_phase_multiplier <= hwdata[1:0];
        aicg_pkg::OFS_SERVO:    servo_divider_setting   <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_div
      localparam logic [7:0] OFS = 8'(aicg_pkg::OFS_HW0 + 4 * g);
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          // R16: default divide by 32
          // R17: filter default four
          hw_div[g] <= (g == 5) ? aicg_pkg::FILT_RESET : aicg_pkg::HW_DIV_RESET;
        end else if (prot_wr && wr_addr == OFS) begin
          hw_div[g] <= hwdata[3:0];
        end
      end
    end
  endgenerate

  // ==========================================================
  // read data, registered for the data phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (rd_addr)
        aicg_pkg::OFS_KEY:      hrdata <= write_unlock_key;
        // R4: accessory part code
        aicg_pkg::OFS_PART:     hrdata <= aicg_pkg::PART_CODE;
        aicg_pkg::OFS_DIR:      hrdata <= {30'h0, clock_direction_select};
        aicg_pkg::OFS_RATE:     hrdata <= phase_rate_hz;
        aicg_pkg::OFS_RX_DIV:   hrdata <= {30'h0, received_phase_divider};
        aicg_pkg::OFS_OUT_MULT: hrdata <= {30'h0, output_phase_multiplier};
        aicg_pkg::OFS_SERVO:    hrdata <= {28'h0, servo_divider_setting};
        aicg_pkg::OFS_STATUS:   hrdata <= {29'h0, phase_locked, servo_tick, phase_tick};
        default: begin
          if (rd_addr >= aicg_pkg::OFS_HW0 && rd_addr <= aicg_pkg::OFS_FILT) begin
            hrdata <= {28'h0, hw_div[3'((rd_addr - aicg_pkg::OFS_HW0) >> 2)]};
          end else begin
            hrdata <= 32'h00000000;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // pin synchronisers: change counts when stages two and three agree
  logic [2:0] ph_sync;
  logic [2:0] sv_sync;
  logic       ph_level;
  logic       sv_level;
  logic       ph_edge;
  logic       sv_edge;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ph_sync  <= 3'h0;
      sv_sync  <= 3'h0;
      ph_level <= 1'b0;
      sv_level <= 1'b0;
    end else begin
      ph_sync <= {ph_sync[1:0], phase_pin_in};
      sv_sync <= {sv_sync[1:0], servo_pin_in};
      if (ph_sync[1] == ph_sync[2]) begin
        ph_level <= ph_sync[2];
      end
      if (sv_sync[1] == sv_sync[2]) begin
        sv_level <= sv_sync[2];
      end
    end
  end
  assign ph_edge = (ph_sync[1] == ph_sync[2]) && ph_sync[2] && !ph_level;
  assign sv_edge = (sv_sync[1] == sv_sync[2]) && sv_sync[2] && !sv_level;

  // ==========================================================
  // received phase divider
  logic [1:0] rx_cnt;
  logic       rx_tick;
  // R9: divide received edges by setting plus one
  assign rx_tick = ph_edge && (rx_cnt == received_phase_divider);
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_cnt <= 2'h0;
    end else if (ph_edge) begin
      rx_cnt <= rx_tick ? 2'h0 : 2'(rx_cnt + 2'h1);
    end
  end

  // ==========================================================
  // phase rate oscillator; wraps rate*(mult+1) times a second
  logic [32:0] acc;
  logic [32:0] step;
  logic [32:0] next_acc;
  logic        wrap;
  logic [1:0]  mult_cnt;
  logic        int_tick;

  // R10: output phase multiplied
  assign step     = 33'(phase_rate_hz * 33'({1'b0, output_phase_multiplier} + 3'h1));
  assign next_acc = acc + step;
  assign wrap     = next_acc >= 33'(aicg_pkg::SYS_CLK_HZ);
  assign int_tick = wrap && (mult_cnt == output_phase_multiplier);

  // R8: digital loop realigns on each divided received phase tick (rx_tick)
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc          <= 33'h0;
      mult_cnt     <= 2'h0;
      phase_locked <= 1'b0;
    end else if (phase_rx && rx_tick) begin
      acc          <= 33'h0;
      mult_cnt     <= 2'h0;
      // locked when the local oscillator was near the wrap that gives its own phase tick (int_tick)
      phase_locked <= (mult_cnt == output_phase_multiplier)
                      && (next_acc + step >= 33'(aicg_pkg::SYS_CLK_HZ));
    end else begin
      acc <= wrap ? 33'(next_acc - 33'(aicg_pkg::SYS_CLK_HZ)) : next_acc;
      if (wrap) begin
        mult_cnt <= int_tick ? 2'h0 : 2'(mult_cnt + 2'h1);
      end
      if (!phase_rx) begin
        phase_locked <= 1'b0;
      end
    end
  end

  // ==========================================================
  // servo divider and clock enables
  logic [3:0] servo_cnt;
  logic       next_phase;
  logic       next_servo;

  // received phase is used when selected, else local oscillator
  assign next_phase = phase_rx ? rx_tick : int_tick;
  // R11: servo over divider plus one
  // R13: received servo overrides divider
  assign next_servo = servo_rx ? sv_edge
                    : (next_phase && servo_cnt == servo_divider_setting);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      servo_cnt <= 4'h0;
    end else if (next_phase) begin
      servo_cnt <= (servo_cnt == servo_divider_setting) ? 4'h0 : 4'(servo_cnt + 4'h1);
    end
  end

  // R20: one-cycle enables
  // R19: ticks pace the host; the pins, from wrap and next_servo, pace the backplane
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      phase_tick    <= 1'b0;
      servo_tick    <= 1'b0;
      phase_pin_out <= 1'b0;
      servo_pin_out <= 1'b0;
    end else begin
      phase_tick    <= next_phase;
      servo_tick    <= next_servo;
      // driven phase runs at the multiplied rate
      phase_pin_out <= wrap && !phase_rx;
      servo_pin_out <= next_servo && !servo_rx;
    end
  end

  // R5: drive pins only when generating
  assign phase_pin_oe = !phase_rx;
  assign servo_pin_oe = !servo_rx;

  // ==========================================================
  // hardware clocks, leaving this block only on hw_clk_en
  localparam int unsigned HW_CNT_W_L = aicg_pkg::HW_CNT_W;
  logic [HW_CNT_W_L-1:0] hw_cnt;
  logic [HW_CNT_W_L-1:0] filt_cnt;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hw_cnt   <= '0;
      filt_cnt <= '0;
    end else begin
      hw_cnt <= hw_cnt + 1'b1;
      if (hw_clk_en[4]) begin
        filt_cnt <= filt_cnt + 1'b1;
      end
    end
  end

  // R14: divide by two to the n
  // R15: five enables from the source clock
  // R18: enables leave this block only on the hw_clk_en port, never on the backplane pins
  generate
    for (g = 0; g < 6; g++) begin : g_hw
      logic [HW_CNT_W_L-1:0] mask;
      logic [HW_CNT_W_L-1:0] cnt;
      assign mask = HW_CNT_W_L'((16'h1 << hw_div[g]) - 16'h1);
      logic                  next_en;
      assign cnt  = (g == 5) ? filt_cnt : hw_cnt;
      assign next_en = ((cnt & mask) == mask);
      always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          hw_clk_en[g] <= 1'b0;
        end else if (g == 5) begin
          // R17: filter derived from sampling enable, one cycle behind it
          hw_clk_en[g] <= hw_clk_en[4] && next_en;
        end else begin
          hw_clk_en[g] <= next_en;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* aicg_properties.sv */
// aicg_properties: port-level checks of bus answers, pins and clock enables.
// assumes it is bound into aicg_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module aicg_checker (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // backplane pins and enables
  input wire logic        phase_pin_out,
  input wire logic        phase_pin_oe,
  input wire logic        servo_pin_out,
  input wire logic        servo_pin_oe,
  input wire logic        phase_tick,
  input wire logic        servo_tick,
  input wire logic [5:0]  hw_clk_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic rd_go;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  // ==========================================================
  // bus answers
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_part_read: assert property (
    rd_go && haddr[7:2] == aicg_pkg::OFS_PART[7:2] |=> hrdata == aicg_pkg::PART_CODE)
    else $error("part code read wrong");
  a_unmapped_zero: assert property (rd_go && haddr[7:2] > 6'h0D |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  // ==========================================================
  // pulses and pins
  a_phase_single: assert property (phase_tick |=> !phase_tick)
    else $error("phase tick longer than one cycle");
  a_servo_single: assert property (servo_tick |=> !servo_tick)
    else $error("servo tick longer than one cycle");
  a_phase_pin_quiet: assert property (!phase_pin_oe [*2] |-> !phase_pin_out)
    else $error("phase pin pulsing while receiving");
  a_servo_pin_quiet: assert property (!servo_pin_oe [*2] |-> !servo_pin_out)
    else $error("servo pin pulsing while receiving");
  a_servo_pin_tick: assert property (servo_pin_oe && servo_pin_out |-> servo_tick)
    else $error("driven servo pulse without servo tick");
  a_filter_follow: assert property (
    hw_clk_en[5] |-> hw_clk_en[4] || $past(hw_clk_en[4]))
    else $error("filter enable not on a sample enable");
endmodule
bind aicg_top aicg_checker i_chk (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_pin_out(phase_pin_out),
  .phase_pin_oe(phase_pin_oe), .servo_pin_out(servo_pin_out), .servo_pin_oe(servo_pin_oe),
  .phase_tick(phase_tick), .servo_tick(servo_tick), .hw_clk_en(hw_clk_en));
`default_nettype wire

/* aicg_peer_model.sv */
// aicg_peer_model: a peer chip acting as the system clock source.
// assumes the bench routes its clocks to the pins only while it runs.
`timescale 1ns/1ns
`default_nettype none
module aicg_peer_model #(
  parameter int PHASE_NS    = 3000,
  parameter int SERVO_EVERY = 4
) (
  // run control
  input  wire logic run,
  // backplane clocks
  output logic      phase_clk,
  output logic      servo_clk
);
  int cnt;
  initial begin
    phase_clk = 1'b0;
    servo_clk = 1'b0;
    cnt = 0;
    // odd offset keeps the peer out of step with clk_sys
    #37;
    forever begin
      wait (run);
      // sole source, servo aligned to a phase edge
      phase_clk = 1'b1;
      servo_clk = (cnt % SERVO_EVERY) == 0;
      #(PHASE_NS / 6);
      phase_clk = 1'b0;
      servo_clk = 1'b0;
      cnt = cnt + 1;
      #(PHASE_NS - PHASE_NS / 6);
    end
  end
endmodule
`default_nettype wire

/* test_aicg_top.sv */
// test_aicg_top: self-checking bench for aicg_top with a peer clock source.
// assumes aicg_pkg, the checker and the peer model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module test_aicg_top;
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, phase_pin_out, phase_pin_oe, servo_pin_out, servo_pin_oe;
  logic        phase_tick, servo_tick, peer_phase, peer_servo;
  logic        peer_run = 1'b0;
  logic [5:0]  hw_clk_en;
  logic [31:0] hrdata, rd;
  logic [31:0] seed = 32'hDC7D0CBD;
  int          miscompares = 0, comparisons = 0, k, g;
  always #50 clk_sys = ~clk_sys;
  aicg_top i_dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .phase_pin_in(phase_pin_oe ? phase_pin_out : peer_phase), .phase_pin_out(phase_pin_out),
    .phase_pin_oe(phase_pin_oe), .servo_pin_in(servo_pin_oe ? servo_pin_out : peer_servo),
    .servo_pin_out(servo_pin_out), .servo_pin_oe(servo_pin_oe), .phase_tick(phase_tick),
    .servo_tick(servo_tick), .hw_clk_en(hw_clk_en));
  aicg_peer_model i_peer (.run(peer_run), .phase_clk(peer_phase), .servo_clk(peer_servo));
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] reset_value(input logic [7:0] a);
    case (a)
      aicg_pkg::OFS_PART: return aicg_pkg::PART_CODE;
      aicg_pkg::OFS_RATE: return 32'h0000234B;
      aicg_pkg::OFS_SERVO: return 32'h3;
      aicg_pkg::OFS_FILT: return 32'h4;
      default: return (a >= aicg_pkg::OFS_HW0 && a < aicg_pkg::OFS_FILT) ? 32'h5 : 32'h0;
    endcase
  endfunction
  function automatic logic pick(input int w);
    logic [8:0] v;
    v = {phase_pin_out, servo_tick, phase_tick, hw_clk_en};
    return v[w];
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // fresh key right before each protected write
  task automatic pw(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, aicg_pkg::OFS_KEY, aicg_pkg::UNLOCK_VALUE);
    bus(1'b1, a, wd);
  endtask
  // cycles between two pulses, after a settling pulse
  task automatic gap(input int w, output int n);
    n = 0;
    repeat (2) begin
      do @(negedge clk_sys); while (pick(w) !== 1'b1);
    end
    do begin
      @(negedge clk_sys);
      n++;
    end while (pick(w) !== 1'b1 && n < 5000);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    #3_000_000;
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a <= 60; a += 4) if (a != 52) rchk(8'(a), reset_value(8'(a)));
    bus(1'b1, aicg_pkg::OFS_SERVO, 32'h7);
    rchk(aicg_pkg::OFS_SERVO, 32'h3);
    seed = lfsr(seed);
    bus(1'b1, aicg_pkg::OFS_KEY, seed & 32'h7FFFFFFF);
    bus(1'b1, aicg_pkg::OFS_SERVO, 32'h7);
    rchk(aicg_pkg::OFS_SERVO, 32'h3);
    rchk(aicg_pkg::OFS_KEY, seed & 32'h7FFFFFFF);
    // accepted write clears key, next one refused
    seed = lfsr(seed);
    pw(aicg_pkg::OFS_SERVO, {28'h0, seed[3:0]});
    rchk(aicg_pkg::OFS_KEY, 32'h0);
    bus(1'b1, aicg_pkg::OFS_SERVO, {28'h0, ~seed[3:0]});
    rchk(aicg_pkg::OFS_SERVO, {28'h0, seed[3:0]});
    pw(aicg_pkg::OFS_PART, 32'h0);
    rchk(aicg_pkg::OFS_PART, aicg_pkg::PART_CODE);
    gap(0, k);
    chk(32'(k), 32'h20);
    for (g = 0; g < 5; g++) begin
      seed = lfsr(seed);
      pw(aicg_pkg::OFS_HW0 + 8'(4 * g), 32'(seed[2:0] % 7));
      gap(g, k);
      chk(32'(k), 32'h1 << (seed[2:0] % 7));
    end
    pw(aicg_pkg::OFS_HW0 + 8'h10, 32'h2);
    pw(aicg_pkg::OFS_FILT, 32'h1);
    gap(5, k);
    chk(32'(k), 32'h8);
    // generated phase at 250 kHz, doubled pin, servo at half the phase rate
    pw(aicg_pkg::OFS_RATE, 32'h0003D090);
    pw(aicg_pkg::OFS_OUT_MULT, 32'h1);
    pw(aicg_pkg::OFS_SERVO, 32'h1);
    gap(8, k);
    chk(32'(k), 32'h14);
    gap(6, k);
    chk(32'(k), 32'h28);
    gap(7, k);
    chk(32'(k), 32'h50);
    // receive both clocks from the peer
    peer_run <= 1'b1;
    pw(aicg_pkg::OFS_RX_DIV, 32'h1);
    pw(aicg_pkg::OFS_SERVO, 32'h0);
    pw(aicg_pkg::OFS_DIR, 32'h3);
    @(negedge clk_sys);
    chk({30'h0, phase_pin_oe, servo_pin_oe}, 32'h0);
    gap(6, k);
    chk(32'(k), 32'h3C);
    gap(7, k);
    chk(32'(k), 32'h78);
    // local oscillator far from the received rate: not locked
    bus(1'b0, aicg_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h0);
    // local wrap lands on the received edge: locked
    pw(aicg_pkg::OFS_RATE, 32'h00028B0B);
    pw(aicg_pkg::OFS_OUT_MULT, 32'h0);
    gap(6, k);
    chk(32'(k), 32'h3C);
    bus(1'b0, aicg_pkg::OFS_STATUS, 32'h0);
    chk(rd & 32'h4, 32'h4);
    pw(aicg_pkg::OFS_DIR, 32'h0);
    @(negedge clk_sys);
    chk({30'h0, phase_pin_oe, servo_pin_oe}, 32'h3);
    peer_run <= 1'b0;
    stop_test;
  end
endmodule
`default_nettype wire
